// file: bench/usb_lowspeed_ctrl_status_test.sv
// self-checking bench for the usb control and status block
`timescale 1ns/100ps

module usb_lowspeed_ctrl_status_test
  import usb_ls_pkg::*;
;
  logic        clk, rst, cpu_dis, nz, awvalid, wvalid, bready, arvalid;
  logic        rready, awready, wready, bvalid, arready, rvalid;
  logic        irq, esirq, tog, stall;
  logic [7:0]  awaddr, araddr, ev;
  logic [31:0] wdata, rdata, d;
  logic [1:0]  bresp, rresp, q, eep, r;
  wire  [3:0]  ctl;
  logic [6:0]  addr;
  tx_state_t   ans;
  token_t      tok;
  int          fails, comparisons;
  logic [7:0]  offs [7] = '{OFF_STATUS, OFF_MASK, OFF_CONTROL, OFF_ADDRESS,
                            OFF_EP0_TX, OFF_EP1_TX, OFF_EP2_TX};
  logic [7:0]  rstv [7] = '{8'h00, 8'h00, 8'h06, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0]  cv [4] = '{8'h08, 8'h04, 8'h02, 8'h00};
  usb_ls_engine_model host (.clk_in(clk), .ev_out(ev), .tok_out(tok),
    .ep_out(eep));
  usb_lowspeed_ctrl_status dut (.REF_CLK_IN(clk), .RESET_IN(rst),
    .S_AXI_AWADDR_IN(awaddr), .S_AXI_AWVALID_IN(awvalid),
    .S_AXI_AWREADY_OUT(awready), .S_AXI_WDATA_IN(wdata),
    .S_AXI_WSTRB_IN(4'hF), .S_AXI_WVALID_IN(wvalid),
    .S_AXI_WREADY_OUT(wready), .S_AXI_BRESP_OUT(bresp),
    .S_AXI_BVALID_OUT(bvalid), .S_AXI_BREADY_IN(bready),
    .S_AXI_ARADDR_IN(araddr), .S_AXI_ARVALID_IN(arvalid),
    .S_AXI_ARREADY_OUT(arready), .S_AXI_RDATA_OUT(rdata),
    .S_AXI_RRESP_OUT(rresp), .S_AXI_RVALID_OUT(rvalid),
    .S_AXI_RREADY_IN(rready), .ERROR_EVENT_IN(ev[0]),
    .KEEPALIVE_IN(ev[1]), .RESUME_DONE_IN(ev[2]), .BUS_RESET_SEEN_IN(ev[3]),
    .BUS_ACTIVITY_IN(ev[4]), .SETUP_PID_IN(ev[5]), .TX_ACKED_IN(ev[6]),
    .XFER_DONE_IN(ev[7]), .XFER_TOKEN_IN(tok), .XFER_EP_IN(eep),
    .QUERY_EP_IN(q), .OUT_NONZERO_IN(nz), .IN_ANSWER_OUT(ans),
    .OUT_STALL_OUT(stall), .TX_TOGGLE_OUT(tog), .CPU_INT_DISABLE_IN(cpu_dis),
    .USB_IRQ_OUT(irq), .END_SUSPEND_IRQ_OUT(esirq),
    .RESUME_DRIVE_OUT(ctl[3]), .REGULATOR_OFF_OUT(ctl[2]),
    .SUSPEND_OUT(ctl[1]), .IFACE_RESET_OUT(ctl[0]),
    .DEVICE_ADDRESS_OUT(addr));
//////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  // ready is sampled mid-cycle, where it equals its value at the next edge
  task automatic wr(logic [7:0] a, logic [7:0] v);
    logic ta, tw, tb;
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h0, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge clk);
      ta = awvalid & awready;
      tw = wvalid & wready;
      tb = bvalid & bready;
      if (tb) r = bresp;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) bready <= 1'b0;
    end while (!tb);
  endtask
  task automatic rd(logic [7:0] a);
    logic t;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge clk);
      t = arready;
      @(posedge clk);
    end while (!t);
    arvalid <= 1'b0;
    do begin
      @(negedge clk);
      t = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clk);
    end while (!t);
    rready <= 1'b0;
  endtask
  task automatic rchk(logic [7:0] a, logic [7:0] e);
    rd(a);
    chk($sformatf("reg %h", a), {24'h0, e}, d);
    chk("read resp", RESP_OKAY, r);
  endtask
  task automatic ev_go(int i, token_t t = TOK_OUT, logic [1:0] e = 2'h1);
    host.send(i, t, e);
    @(negedge clk);
  endtask
  task automatic report_and_stop();
    $display("fails %0d comparisons %0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
//////////////////////////////////////////////////////////////////////////////
  initial begin
    #100000;
    fails++;
    report_and_stop();
  end
  initial begin
    {rst, cpu_dis, nz, awvalid, wvalid, bready, arvalid, rready} = 8'h80;
    {awaddr, araddr, wdata, q, fails, comparisons} = '0;
    q = 2'h1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    foreach (offs[i]) rchk(offs[i], rstv[i]);
    rd(8'h1C);
    chk("unmapped resp", RESP_SLVERR, r);
    chk("unmapped data", 32'h0, d);
    wr(OFF_ADDRESS, 8'hFF);
    chk("write resp", RESP_OKAY, r);
    chk("address pin", 32'h7F, addr);
    rchk(OFF_ADDRESS, 8'h7F);
    wr(8'h1C, 8'h55);
    chk("unmapped write resp", RESP_SLVERR, r);
    wr(OFF_EP0_TX, 8'h35);
    ev_go(3);
    rchk(OFF_ADDRESS, 8'h00);
    chk("address pin", 32'h00, addr);
    rchk(OFF_EP0_TX, 8'h00);
    rchk(OFF_STATUS, 8'h02);
    wr(OFF_STATUS, 8'h00);
    ev_go(2);
    rchk(OFF_STATUS, 8'h01);
    ev_go(0);
    rchk(OFF_STATUS, 8'h11);
    ev_go(0);
    rchk(OFF_STATUS, 8'h19);
    wr(OFF_STATUS, 8'h01);
    ev_go(1);
    rchk(OFF_STATUS, 8'h09);
    wr(OFF_STATUS, 8'hFF);
    rchk(OFF_STATUS, 8'h09);
    wr(OFF_MASK, 8'h08);
    chk("irq", 1'b1, irq);
    @(posedge clk);
    cpu_dis <= 1'b1;
    @(negedge clk);
    chk("irq", 1'b0, irq);
    @(posedge clk);
    cpu_dis <= 1'b0;
    wr(OFF_MASK, 8'h04);
    chk("irq", 1'b0, irq);
    wr(OFF_STATUS, 8'h00);
    ev_go(4);
    chk("suspend", 1'b0, ctl[1]);
    chk("end suspend irq", 1'b1, esirq);
    chk("irq", 1'b0, irq);
    rchk(OFF_STATUS, 8'h04);
    wr(OFF_STATUS, 8'h00);
    ev_go(4);
    rchk(OFF_STATUS, 8'h00);
    foreach (cv[i]) begin
      wr(OFF_CONTROL, cv[i]);
      chk("control pins", cv[i], ctl);
      if (cv[i] == 8'h02) repeat (60) @(posedge clk);
    end
    repeat (300) @(posedge clk);
    wr(OFF_MASK, 8'h02);
    wr(OFF_CONTROL, 8'h01);
    wr(OFF_ADDRESS, 8'h12);
    rchk(OFF_ADDRESS, 8'h00);
    wr(OFF_CONTROL, 8'h00);
    chk("irq", 1'b1, irq);
    rchk(OFF_STATUS, 8'h02);
    for (int s = 0; s < 4; s++) begin
      wr(OFF_EP1_TX, 8'(s << 4));
      chk("in answer", s, ans);
    end
    wr(OFF_EP1_TX, 8'hB5);
    @(posedge clk);
    nz <= 1'b1;
    @(negedge clk);
    chk("stall", 1'b1, stall);
    wr(OFF_EP1_TX, 8'h35);
    chk("stall", 1'b0, stall);
    ev_go(5);
    chk("toggle", 1'b1, tog);
    ev_go(6);
    chk("toggle", 1'b0, tog);
    ev_go(7);
    rchk(OFF_EP1_TX, 8'h35);
    ev_go(7, TOK_IN);
    rchk(OFF_EP1_TX, 8'h25);
    wr(OFF_EP2_TX, 8'h30);
    ev_go(7, TOK_SETUP, 2'h2);
    rchk(OFF_EP2_TX, 8'h20);
    @(posedge clk);
    q <= 2'h3;
    @(negedge clk);
    chk("in answer", TX_DISABLED, ans);
    report_and_stop();
  end
endmodule

// file: bench/usb_ls_assertions.sv
// port checks for the usb control and status block
`timescale 1ns/100ps

module usb_ls_assertions
  import usb_ls_pkg::*;
(
  input wire logic       REF_CLK_IN,
  input wire logic       RESET_IN,
  input wire logic       BUS_RESET_SEEN_IN,
  input wire logic       BUS_ACTIVITY_IN,
  input wire logic       SETUP_PID_IN,
  input wire logic       TX_ACKED_IN,
  input wire logic       XFER_DONE_IN,
  input wire token_t     XFER_TOKEN_IN,
  input wire logic [1:0] XFER_EP_IN,
  input wire logic [1:0] QUERY_EP_IN,
  input wire logic       OUT_NONZERO_IN,
  input wire tx_state_t  IN_ANSWER_OUT,
  input wire logic       OUT_STALL_OUT,
  input wire logic       TX_TOGGLE_OUT,
  input wire logic       CPU_INT_DISABLE_IN,
  input wire logic       USB_IRQ_OUT,
  input wire logic       END_SUSPEND_IRQ_OUT,
  input wire logic       SUSPEND_OUT,
  input wire logic       IFACE_RESET_OUT,
  input wire logic [6:0] DEVICE_ADDRESS_OUT
);
  default clocking cb @(posedge REF_CLK_IN);
  endclocking
  default disable iff (RESET_IN);
  // event on the queried endpoint; a reset in the way would zero it
  sequence s_ep_hit;
    XFER_EP_IN == QUERY_EP_IN && XFER_EP_IN != 2'h3 && !BUS_RESET_SEEN_IN
    && !IFACE_RESET_OUT ##1 $stable(QUERY_EP_IN) && !IFACE_RESET_OUT;
  endsequence
  property p_bus_reset;
    BUS_RESET_SEEN_IN |=> DEVICE_ADDRESS_OUT == 7'h00;
  endproperty
  a_bus_reset: assert property (p_bus_reset)
    else $error("address kept over bus reset");
  property p_force_reset;
    IFACE_RESET_OUT && $past(IFACE_RESET_OUT) |-> DEVICE_ADDRESS_OUT == 7'h00;
  endproperty
  a_force_reset: assert property (p_force_reset)
    else $error("address not held in forced reset");
  property p_wake; BUS_ACTIVITY_IN |=> !SUSPEND_OUT; endproperty
  a_wake: assert property (p_wake)
    else $error("suspend kept after activity");
  property p_irq_off;
    CPU_INT_DISABLE_IN |-> !USB_IRQ_OUT && !END_SUSPEND_IRQ_OUT;
  endproperty
  a_irq_off: assert property (p_irq_off)
    else $error("interrupt while processor disabled");
  property p_no_stall; !OUT_NONZERO_IN |-> !OUT_STALL_OUT; endproperty
  a_no_stall: assert property (p_no_stall)
    else $error("stall on empty out data");
  property p_no_ep;
    QUERY_EP_IN == 2'h3 |-> IN_ANSWER_OUT == TX_DISABLED;
  endproperty
  a_no_ep: assert property (p_no_ep)
    else $error("absent endpoint not disabled");
  property p_setup; SETUP_PID_IN ##0 s_ep_hit |-> TX_TOGGLE_OUT; endproperty
  a_setup: assert property (p_setup)
    else $error("toggle not set by setup");
  property p_ack;
    (TX_ACKED_IN && !SETUP_PID_IN) ##0 s_ep_hit
      |-> TX_TOGGLE_OUT != $past(TX_TOGGLE_OUT);
  endproperty
  a_ack: assert property (p_ack)
    else $error("toggle not inverted by ack");
  property p_nak;
    (XFER_DONE_IN && XFER_TOKEN_IN != TOK_OUT) ##0 s_ep_hit
      |-> IN_ANSWER_OUT == TX_NAK;
  endproperty
  a_nak: assert property (p_nak)
    else $error("endpoint not naked after transfer");
endmodule

bind usb_lowspeed_ctrl_status usb_ls_assertions ports_chk (
  .REF_CLK_IN, .RESET_IN, .BUS_RESET_SEEN_IN, .BUS_ACTIVITY_IN,
  .SETUP_PID_IN, .TX_ACKED_IN, .XFER_DONE_IN, .XFER_TOKEN_IN, .XFER_EP_IN,
  .QUERY_EP_IN, .OUT_NONZERO_IN, .IN_ANSWER_OUT, .OUT_STALL_OUT,
  .TX_TOGGLE_OUT, .CPU_INT_DISABLE_IN, .USB_IRQ_OUT, .END_SUSPEND_IRQ_OUT,
  .SUSPEND_OUT, .IFACE_RESET_OUT, .DEVICE_ADDRESS_OUT);

// file: bench/usb_ls_engine_model.sv
// serial engine stand-in: one-cycle event strobes with token and endpoint
`timescale 1ns/100ps

module usb_ls_engine_model
  import usb_ls_pkg::*;
(
  input  wire logic  clk_in,
  output logic [7:0] ev_out,
  output token_t     tok_out,
  output logic [1:0] ep_out
);
  initial begin
    ev_out = 8'h00;
    tok_out = TOK_OUT;
    ep_out = 2'h0;
  end
  // endpoint is scrambled after the strobe so a stale value never matches
  task automatic send(input int i, input token_t t, input logic [1:0] e);
    @(posedge clk_in);
    ev_out[i] <= 1'b1;
    tok_out <= t;
    ep_out <= e;
    @(posedge clk_in);
    ev_out <= 8'h00;
    ep_out <= ~e;
  endtask
endmodule

// file: rtl/usb_lowspeed_ctrl_status.sv
// control, status, mask, address and endpoint transmit registers
//
// Summary of operation
// - overrun when error or frame flag re-raised
// - wake activity during suspend sets end-suspend flag
// - end-suspend has its own interrupt output
// - detected bus reset sets bus-reset flag
// - bus reset clears address and endpoint registers
// - keep-alive or resume completion sets frame flag
// - interrupt needs flag, mask bit, enabled processor
// - resume bit drives resume signalling
// - power-down bit switches the regulator off
// - force-suspend set by software, cleared on activity
// - force-reset holds reset, release raises flag
// - seven-bit address, top bit reads zero
// - status-out stalls nonzero out data
// - setup sets toggle, host ack flips it
// - two-bit transmit state decode
// - correct in or setup transfer naks endpoint
// - endpoint registers reset by bus reset
`timescale 1ns/100ps

module usb_lowspeed_ctrl_status
  import usb_ls_pkg::*;
(
  input  wire logic                  REF_CLK_IN,
  input  wire logic                  RESET_IN,
  // axi4-lite slave
  input  wire logic [AXI_ADDR_W-1:0] S_AXI_AWADDR_IN,
  input  wire logic                  S_AXI_AWVALID_IN,
  output logic                       S_AXI_AWREADY_OUT,
  input  wire logic [AXI_DATA_W-1:0] S_AXI_WDATA_IN,
  input  wire logic [3:0]            S_AXI_WSTRB_IN,
  input  wire logic                  S_AXI_WVALID_IN,
  output logic                       S_AXI_WREADY_OUT,
  output logic [1:0]                 S_AXI_BRESP_OUT,
  output logic                       S_AXI_BVALID_OUT,
  input  wire logic                  S_AXI_BREADY_IN,
  input  wire logic [AXI_ADDR_W-1:0] S_AXI_ARADDR_IN,
  input  wire logic                  S_AXI_ARVALID_IN,
  output logic                       S_AXI_ARREADY_OUT,
  output logic [AXI_DATA_W-1:0]      S_AXI_RDATA_OUT,
  output logic [1:0]                 S_AXI_RRESP_OUT,
  output logic                       S_AXI_RVALID_OUT,
  input  wire logic                  S_AXI_RREADY_IN,
  // events from the serial engine, same clock
  input  wire logic                  ERROR_EVENT_IN,
  input  wire logic                  KEEPALIVE_IN,
  input  wire logic                  RESUME_DONE_IN,
  input  wire logic                  BUS_RESET_SEEN_IN,
  input  wire logic                  BUS_ACTIVITY_IN,
  input  wire logic                  SETUP_PID_IN,
  input  wire logic                  TX_ACKED_IN,
  input  wire logic                  XFER_DONE_IN,
  input  wire token_t                XFER_TOKEN_IN,
  input  wire logic [1:0]            XFER_EP_IN,
  // handshake query from the serial engine
  input  wire logic [1:0]            QUERY_EP_IN,
  input  wire logic                  OUT_NONZERO_IN,
  output tx_state_t                  IN_ANSWER_OUT,
  output logic                       OUT_STALL_OUT,
  output logic                       TX_TOGGLE_OUT,
  // processor side
  input  wire logic                  CPU_INT_DISABLE_IN,
  output logic                       USB_IRQ_OUT,
  output logic                       END_SUSPEND_IRQ_OUT,
  // transceiver and engine control
  output logic                       RESUME_DRIVE_OUT,
  output logic                       REGULATOR_OFF_OUT,
  output logic                       SUSPEND_OUT,
  output logic                       IFACE_RESET_OUT,
  output logic [6:0]                 DEVICE_ADDRESS_OUT
);

  ctrl_state_t state;
  ctrl_state_t next_state;

  ////////////////////////////////////////////////////////////////////////
  // register map, one byte per aligned word, data in bits 7:0
  //
  //   0x00  status flags, bits 5:0 live, 7:6 read zero
  //   0x04  mask, one bit per status flag
  //   0x08  control: resume, power-down, force-suspend, force-reset
  //   0x0C  device address, bit 7 reads zero
  //   0x10  endpoint 0 transmit control
  //   0x14  endpoint 1 transmit control
  //   0x18  endpoint 2 transmit control
  //
  // any other offset answers slverr; reads give zero, writes are dropped

  ////////////////////////////////////////////////////////////////////////
  // bus timing
  //
  // write: address and data are latched in their own slots, in either
  // order; each ready drops while its slot is full. the store happens
  // on the edge after both slots hold, and bvalid rises on that edge.
  // a new address or data word may be latched while bvalid is still
  // high, but the store waits until the response has been taken.
  //
  // read: the read decode uses the state as it stands, so the answer
  // is registered on the same edge that takes the address. arready is
  // low while a read answer is pending, one read in flight at a time.
  //
  // only byte lane zero matters; a write with that strobe low is
  // answered okay at a mapped offset and changes nothing.

  ////////////////////////////////////////////////////////////////////////
  // flag behaviour
  //
  // all engine events are single-cycle strobes on this clock, applied
  // at the next edge. a hardware set and a software clear in the same
  // cycle leave the flag set, so no event is ever lost to a clear that
  // was aimed at an older one.
  //
  // overrun looks at the flag as it stood before this cycle's write,
  // so a clear and a fresh event in one cycle still count as overrun;
  // the trade is a rare extra overrun against a missed one.
  //
  // end-suspend only fires while force-suspend is set; activity clears
  // force-suspend even if software writes it high in the same cycle.

  ////////////////////////////////////////////////////////////////////////
  // reset behaviour
  //
  // a detected bus reset clears the address and all endpoint registers
  // for every cycle it is seen, but leaves control and mask alone.
  // force-reset does the same for as long as software keeps the bit
  // set, so writes to the address or endpoints are lost meanwhile.
  // releasing force-reset raises the bus-reset flag exactly once.

  ////////////////////////////////////////////////////////////////////////
  // endpoint behaviour
  //
  // the engine updates an endpoint in the same cycle as a software
  // write would; the engine wins field by field, since its update
  // reflects a transfer that has already happened on the bus.
  // setup wins over ack when both hit the toggle in one cycle.
  // the byte count is kept as written; its range is up to software.
  // queries for an endpoint that is not fitted answer as disabled,
  // so the engine never sees a stale or undefined state.

  ////////////////////////////////////////////////////////////////////////
  // register read decode

  function automatic logic [7:0] read_reg(input ctrl_state_t s,
                                          input logic [AXI_ADDR_W-1:0] a,
                                          output logic hit);
    logic [7:0] v;
    v   = 8'h00;
    hit = 1'b1;
    case (a)
      OFF_STATUS:  v = s.status & STATUS_IMPL;
      OFF_MASK:    v = s.mask;
      OFF_CONTROL: v = {4'h0, s.control};
      OFF_ADDRESS: v = {1'b0, s.address};
      OFF_EP0_TX:  v = s.ep_tx[0];
      OFF_EP1_TX:  v = s.ep_tx[1];
      OFF_EP2_TX:  v = s.ep_tx[2];
      default:     hit = 1'b0;
    endcase
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic [7:0]  wd;
    logic        do_write;
    logic        hit;
    logic [7:0]  rv;
    logic [7:0]  sets;
    logic        in_reset;
    logic        force_bus_reset_release;
    logic [1:0]  ep_idx;
    wd           = 8'h00;
    do_write     = 1'b0;
    hit          = 1'b0;
    rv           = 8'h00;
    sets         = 8'h00;
    in_reset     = 1'b0;
    force_bus_reset_release = 1'b0;
    ep_idx       = 2'h0;
    next_state   = state;

    // address and data are taken independently, in either order
    if (S_AXI_AWVALID_IN && !state.aw_held) begin
      next_state.aw_held = 1'b1;
      next_state.aw_addr = S_AXI_AWADDR_IN;
    end
    if (S_AXI_WVALID_IN && !state.w_held) begin
      next_state.w_held  = 1'b1;
      next_state.w_data  = S_AXI_WDATA_IN[7:0];
      next_state.w_lane0 = S_AXI_WSTRB_IN[0];
    end
    if (state.bvalid && S_AXI_BREADY_IN) begin
      next_state.bvalid = 1'b0;
    end
    if (state.rvalid && S_AXI_RREADY_IN) begin
      next_state.rvalid = 1'b0;
    end

    // read: answered on the same edge that takes the address
    if (S_AXI_ARVALID_IN && !state.rvalid) begin
      rv = read_reg(state, S_AXI_ARADDR_IN, hit);
      next_state.rvalid = 1'b1;
      next_state.rdata  = rv;
      next_state.rresp  = hit ? RESP_OKAY : RESP_SLVERR;
    end

    // write: performed once both halves are held
    if (state.aw_held && state.w_held && !state.bvalid) begin
      do_write = state.w_lane0;
      wd       = state.w_data;
      rv       = read_reg(state, state.aw_addr, hit);
      next_state.aw_held = 1'b0;
      next_state.w_held  = 1'b0;
      next_state.bvalid  = 1'b1;
      next_state.bresp   = hit ? RESP_OKAY : RESP_SLVERR;
    end

    if (do_write) begin
      case (state.aw_addr)
        // zero clears a flag, one keeps it; software cannot set one
        OFF_STATUS:  next_state.status = state.status & wd;
        OFF_MASK:    next_state.mask = wd;
        OFF_CONTROL: begin
          next_state.control = wd[3:0];
          force_bus_reset_release = state.control[CT_FORCE_BUS_RESET] && !wd[CT_FORCE_BUS_RESET];
        end
        OFF_ADDRESS: next_state.address = wd[6:0];
        OFF_EP0_TX:  next_state.ep_tx[0] = wd;
        OFF_EP1_TX:  next_state.ep_tx[1] = wd;
        OFF_EP2_TX:  next_state.ep_tx[2] = wd;
        default:     next_state.control = next_state.control;
      endcase
    end

    // hardware events; applied after the write so a set wins a clear
    sets[ST_ERR] = ERROR_EVENT_IN;
    sets[ST_SOF] = KEEPALIVE_IN || RESUME_DONE_IN;
    sets[ST_BUSRST] = BUS_RESET_SEEN_IN || force_bus_reset_release;
    sets[ST_END_SUSPEND_FLAG] = state.control[CT_FORCE_SUSPEND] && BUS_ACTIVITY_IN;
    sets[ST_XFER] = XFER_DONE_IN;
    // a re-raise of an uncleared error or frame flag is an overrun
    sets[ST_OVR] = (ERROR_EVENT_IN && state.status[ST_ERR])
                || (sets[ST_SOF] && state.status[ST_SOF]);
    next_state.status = (next_state.status | sets) & STATUS_IMPL;

    // activity ends forced suspend, even against a software write
    if (BUS_ACTIVITY_IN) begin
      next_state.control[CT_FORCE_SUSPEND] = 1'b0;
    end

    // endpoint updates by the serial engine
    for (int i = 0; i < EP_COUNT; i++) begin
      ep_idx = i[1:0];
      if (SETUP_PID_IN && XFER_EP_IN == ep_idx) begin
        next_state.ep_tx[i][EP_TOGGLE] = 1'b1;
      end else if (TX_ACKED_IN && XFER_EP_IN == ep_idx) begin
        next_state.ep_tx[i][EP_TOGGLE] = !state.ep_tx[i][EP_TOGGLE];
      end
      if (XFER_DONE_IN && XFER_EP_IN == ep_idx
          && (XFER_TOKEN_IN == TOK_IN || XFER_TOKEN_IN == TOK_SETUP))
      begin
        next_state.ep_tx[i][EP_ST_HI:EP_ST_LO] = TX_NAK;
      end
    end

    // bus reset, or forced reset held by software, clears the
    // address and every endpoint; the forced case holds it there
    in_reset = BUS_RESET_SEEN_IN || next_state.control[CT_FORCE_BUS_RESET];
    if (in_reset) begin
      next_state.address = ADDRESS_RESET;
      next_state.ep_tx   = {EP_COUNT{EP_TX_RESET}};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge REF_CLK_IN) begin
    if (RESET_IN) begin
      state <= STATE_RESET;
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  logic [7:0] pending;
  logic [7:0] query_ep;

  assign S_AXI_AWREADY_OUT = !state.aw_held;
  assign S_AXI_WREADY_OUT  = !state.w_held;
  assign S_AXI_BVALID_OUT  = state.bvalid;
  assign S_AXI_BRESP_OUT   = state.bresp;
  assign S_AXI_ARREADY_OUT = !state.rvalid;
  assign S_AXI_RVALID_OUT  = state.rvalid;
  assign S_AXI_RDATA_OUT   = {{(AXI_DATA_W-8){1'b0}}, state.rdata};
  assign S_AXI_RRESP_OUT   = state.rresp;

  // end-suspend wakes a halted processor, so it leaves on its own line
  assign pending = state.status & state.mask;
  assign USB_IRQ_OUT = !CPU_INT_DISABLE_IN
                     && |(pending & ~(8'h01 << ST_END_SUSPEND_FLAG));
  assign END_SUSPEND_IRQ_OUT = !CPU_INT_DISABLE_IN
                             && pending[ST_END_SUSPEND_FLAG];

  assign RESUME_DRIVE_OUT   = state.control[CT_RESUME];
  assign REGULATOR_OFF_OUT  = state.control[CT_REGULATOR_POWER_DOWN];
  assign SUSPEND_OUT        = state.control[CT_FORCE_SUSPEND];
  assign IFACE_RESET_OUT    = state.control[CT_FORCE_BUS_RESET];
  assign DEVICE_ADDRESS_OUT = state.address;

  // an unfitted endpoint index answers as disabled
  assign query_ep = (QUERY_EP_IN < 2'(EP_COUNT)) ? state.ep_tx[QUERY_EP_IN]
                                                 : EP_TX_RESET;
  assign IN_ANSWER_OUT = tx_state_t'(query_ep[EP_ST_HI:EP_ST_LO]);
  assign OUT_STALL_OUT = query_ep[EP_STOUT] && OUT_NONZERO_IN;
  assign TX_TOGGLE_OUT = query_ep[EP_TOGGLE];

endmodule

// file: shared/usb_ls_pkg.sv
// register map, field layout and state types of the usb control block
package usb_ls_pkg;

  localparam int AXI_ADDR_W = 8;
  localparam int AXI_DATA_W = 32;
  localparam int EP_COUNT   = 3;

  // register byte offsets
  localparam logic [7:0] OFF_STATUS  = 8'h00;
  localparam logic [7:0] OFF_MASK    = 8'h04;
  localparam logic [7:0] OFF_CONTROL = 8'h08;
  localparam logic [7:0] OFF_ADDRESS = 8'h0C;
  localparam logic [7:0] OFF_EP0_TX  = 8'h10;
  localparam logic [7:0] OFF_EP1_TX  = 8'h14;
  localparam logic [7:0] OFF_EP2_TX  = 8'h18;

  // status flag positions
  localparam int ST_SOF    = 0;
  localparam int ST_BUSRST = 1;
  localparam int ST_END_SUSPEND_FLAG  = 2;
  localparam int ST_OVR    = 3;
  localparam int ST_ERR    = 4;
  localparam int ST_XFER   = 5;
  localparam logic [7:0] STATUS_IMPL = 8'h3F;

  // control bit positions
  localparam int CT_FORCE_BUS_RESET   = 0;
  localparam int CT_FORCE_SUSPEND  = 1;
  localparam int CT_REGULATOR_POWER_DOWN   = 2;
  localparam int CT_RESUME = 3;

  // endpoint transmit control fields
  localparam int EP_STOUT  = 7;
  localparam int EP_TOGGLE = 6;
  localparam int EP_ST_HI  = 5;
  localparam int EP_ST_LO  = 4;

  localparam logic [7:0] STATUS_RESET  = 8'h00;
  localparam logic [7:0] MASK_RESET    = 8'h00;
  localparam logic [3:0] CONTROL_RESET = 4'h6;
  localparam logic [6:0] ADDRESS_RESET = 7'h00;
  localparam logic [7:0] EP_TX_RESET   = 8'h00;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // transmit state codes
  typedef enum logic [1:0] {
    TX_DISABLED = 2'h0,
    TX_STALL    = 2'h1,
    TX_NAK      = 2'h2,
    TX_VALID    = 2'h3
  } tx_state_t;

  // token kind of a finished correct transfer
  typedef enum logic [1:0] {
    TOK_OUT   = 2'h0,
    TOK_IN    = 2'h2,
    TOK_SETUP = 2'h3
  } token_t;

  typedef struct packed {
    logic                    aw_held;
    logic [AXI_ADDR_W-1:0]   aw_addr;
    logic                    w_held;
    logic [7:0]              w_data;
    logic                    w_lane0;
    logic                    bvalid;
    logic [1:0]              bresp;
    logic                    rvalid;
    logic [7:0]              rdata;
    logic [1:0]              rresp;
    logic [7:0]              status;
    logic [7:0]              mask;
    logic [3:0]              control;
    logic [6:0]              address;
    logic [EP_COUNT-1:0][7:0] ep_tx;
  } ctrl_state_t;

  localparam ctrl_state_t STATE_RESET = '{
    aw_held: 1'b0, aw_addr: '0, w_held: 1'b0, w_data: 8'h00,
    w_lane0: 1'b0, bvalid: 1'b0, bresp: RESP_OKAY, rvalid: 1'b0,
    rdata: 8'h00, rresp: RESP_OKAY, status: STATUS_RESET,
    mask: MASK_RESET, control: CONTROL_RESET, address: ADDRESS_RESET,
    ep_tx: {EP_COUNT{EP_TX_RESET}}
  };

endpackage
